// >>> hw/aocr_top.sv
`timescale 1ns/100ps
`default_nettype none
module aocr_top
   import aocr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        double_speed,
   input  wire logic        clock_error_pin,
   input  wire logic        overcurrent_pin,
   input  wire logic        dc_offset_pin,
   input  wire logic        overtemp_pin,
   input  wire logic        speaker_shutdown_n,
   input  wire logic        sample_valid,
   input  wire logic [23:0] left_sample,
   input  wire logic [23:0] right_sample,
   output logic             paralleled_bridge_mode,
   output logic      [4:0]  switch_mult,
   output logic      [1:0]  amp_gain_code,
   output logic      [6:0]  ocl_percent,
   output logic      [23:0] ch_a_sample,
   output logic      [23:0] ch_b_sample,
   output logic             amp_run,
   output logic             irq
);
   aocr_cfg_t             cfg_r;        // Output configuration register.
   logic      [1:0]       thr_r;        // Overcurrent limit level.
   aocr_flt_t             flt_r;        // Fault flags.
   logic      [3:0]       stat_r;       // Sticky interrupt status.
   logic      [3:0]       stat_nxt;     // Next interrupt status.
   logic      [3:0]       mask_r;       // Interrupt mask.
   logic      [31:0]      prdata_r;     // Read data caught in setup.
   logic                  bad_r;        // Setup hit no usable register.
   logic [AOCR_NPIN-1:0]  pin_meta_r;   // First synchroniser stage.
   logic [AOCR_NPIN-1:0]  pin_sync_r;   // Second synchroniser stage.
   logic                  sd_prev_r;    // Shutdown level one cycle ago.
   logic [4:0]            mult_r;       // Switching multiple.
   logic [6:0]            pct_r;        // Threshold in percent.
   logic                  run_r;        // Normal operation.
   logic [23:0]           cha_r;        // Channel A sample.
   logic [23:0]           chb_r;        // Channel B sample.
   logic                  setup;        // APB setup cycle.
   logic                  acc;          // APB access completing.
   logic                  wr;           // Write taking effect.
   logic                  sd_toggle;    // Shutdown pin changed.
   aocr_flt_t             flt_in;       // Synchronised fault inputs.
   aocr_flt_t             flt_nxt;      // Next fault flags.
   logic [3:0]            evt;          // Fault events this cycle.
   logic [7:0]            fault_rd;     // Fault register read value.

   // Handshake decode; the slave answers in the first access cycle.
   assign setup   = psel & ~penable;
   assign acc     = psel & penable;
   assign wr      = acc & pwrite & ~bad_r & pstrb[0];
   assign pready  = acc;
   assign pslverr = acc & bad_r;
   assign prdata  = prdata_r;

   // Two flip-flops on every pin before logic reads it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // The shutdown stages start at the pin's idle high level, so no false toggle follows reset.
         pin_meta_r    <= '0;
         pin_meta_r[5] <= 1'b1;
         pin_sync_r    <= '0;
         pin_sync_r[5] <= 1'b1;
      end else begin
         pin_meta_r <= {speaker_shutdown_n, double_speed, clock_error_pin,
                        overcurrent_pin, dc_offset_pin, overtemp_pin};
         pin_sync_r <= pin_meta_r;
      end
   end
   assign flt_in    = pin_sync_r[3:0];
   assign sd_toggle = pin_sync_r[5] ^ sd_prev_r;

   // Fault flags: clock fault follows, the others latch.
   always_comb begin
      flt_nxt.clk = flt_in.clk;
      flt_nxt.ovc = flt_in.ovc | (flt_r.ovc & ~sd_toggle);
      flt_nxt.dc  = flt_in.dc  | (flt_r.dc  & ~sd_toggle);
      flt_nxt.ot  = flt_in.ot  | (flt_r.ot  & ~sd_toggle);
   end
   assign evt = flt_nxt & ~flt_r;

   // Fault flag register and shutdown edge memory.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_r     <= '0;
         sd_prev_r <= 1'b1;
      end else begin
         flt_r     <= flt_nxt;
         sd_prev_r <= pin_sync_r[5];
      end
   end

   // Run only with no fault and the shutdown pin released.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else begin
         run_r <= ~(|flt_nxt) & pin_sync_r[5];
      end
   end

   // Output configuration register writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= AOCR_OUTCFG_RST;
      end else if (wr && paddr == AOCR_ADDR_OUTCFG) begin
         cfg_r.pbe  <= pwdata[7];
         cfg_r.rate <= pwdata[6:4];
         cfg_r.pick <= pwdata[1];
         cfg_r.rsvd <= pwdata[0];
         // A reserved gain code leaves the old gain in place.
         if (pwdata[3:2] != AOCR_GAIN_RSVD) begin
            cfg_r.gain <= pwdata[3:2];
         end
      end
   end

   // Overcurrent limit level; only bits 5:4 are writable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_r <= AOCR_THR_RST;
      end else if (wr && paddr == AOCR_ADDR_FAULT) begin
         thr_r <= pwdata[AOCR_FLT_THR_LO+1:AOCR_FLT_THR_LO];
      end
   end

   // Interrupt mask register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= AOCR_IRQ_RST;
      end else if (wr && paddr == AOCR_ADDR_IRQ_MASK) begin
         mask_r <= pwdata[3:0];
      end
   end

   // Status clears on read of the bits returned; a new event wins.
   always_comb begin
      stat_nxt = stat_r;
      if (acc && !pwrite && !bad_r && paddr == AOCR_ADDR_IRQ_STAT) begin
         stat_nxt = stat_r & ~prdata_r[3:0];
      end
      stat_nxt = stat_nxt | evt;
   end

   // Sticky status register and interrupt line.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= AOCR_IRQ_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end
   assign irq = |(stat_r & mask_r);

   // Fault register read layout with reserved bits at zero.
   always_comb begin
      fault_rd = 8'h00;
      fault_rd[AOCR_FLT_THR_LO+1:AOCR_FLT_THR_LO] = thr_r;
      fault_rd[AOCR_FLT_CLK] = flt_r.clk;
      fault_rd[AOCR_FLT_OVC] = flt_r.ovc;
      fault_rd[AOCR_FLT_DC]  = flt_r.dc;
      fault_rd[AOCR_FLT_OT]  = flt_r.ot;
   end

   // Read data and error are caught in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         bad_r    <= 1'b0;
      end else if (setup) begin
         bad_r    <= 1'b0;
         prdata_r <= '0;
         unique case (paddr)
            AOCR_ADDR_OUTCFG:   prdata_r[7:0] <= cfg_r;
            AOCR_ADDR_FAULT:    prdata_r[7:0] <= fault_rd;
            AOCR_ADDR_IRQ_STAT: prdata_r[3:0] <= stat_r;
            AOCR_ADDR_IRQ_MASK: prdata_r[3:0] <= mask_r;
            // Register seven and any other address answer with an error.
            default:            bad_r <= 1'b1;
         endcase
      end
   end

   // Switching multiple, halved in double speed mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult_r <= 5'h10;
      end else if (pin_sync_r[4]) begin
         mult_r <= aocr_rate_mult(cfg_r.rate) >> 1;
      end else begin
         mult_r <= aocr_rate_mult(cfg_r.rate);
      end
   end

   // Overcurrent threshold in percent of nominal.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pct_r <= 7'h64;
      end else begin
         unique case (thr_r)
            2'h0: pct_r <= 7'h64;
            2'h1: pct_r <= 7'h4b;
            2'h2: pct_r <= 7'h32;
            2'h3: pct_r <= 7'h19;
         endcase
      end
   end

   // Sample routing; silence while normal operation is stopped.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cha_r <= '0;
         chb_r <= '0;
      end else if (!run_r) begin
         cha_r <= '0;
         chb_r <= '0;
      end else if (sample_valid) begin
         if (!cfg_r.pbe) begin
            cha_r <= left_sample;
            chb_r <= right_sample;
         end else if (cfg_r.pick) begin
            cha_r <= left_sample;
            chb_r <= left_sample;
         end else begin
            cha_r <= right_sample;
            chb_r <= right_sample;
         end
      end
   end

   assign paralleled_bridge_mode = cfg_r.pbe;
   assign amp_gain_code = cfg_r.gain;
   assign switch_mult   = mult_r;
   assign ocl_percent   = pct_r;
   assign ch_a_sample   = cha_r;
   assign ch_b_sample   = chb_r;
   assign amp_run       = run_r;

   property p_mode;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == AOCR_ADDR_OUTCFG) |=> (paralleled_bridge_mode == $past(pwdata[7]));
   endproperty
   a_mode: assert property (p_mode) else $error("mode bit not written");

   property p_rate;
      @(posedge pclk) disable iff (!presetn)
      !pin_sync_r[4] |=> (switch_mult == aocr_rate_mult($past(cfg_r.rate)));
   endproperty
   a_rate: assert property (p_rate) else $error("switching multiple wrong");

   property p_half;
      @(posedge pclk) disable iff (!presetn)
      pin_sync_r[4] |=> ({switch_mult, 1'b0} == {1'b0, aocr_rate_mult($past(cfg_r.rate))});
   endproperty
   a_half: assert property (p_half) else $error("double speed not halved");

   property p_gain;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == AOCR_ADDR_OUTCFG) |=>
         (amp_gain_code == (($past(pwdata[3:2]) == AOCR_GAIN_RSVD) ? $past(amp_gain_code) : $past(pwdata[3:2])));
   endproperty
   a_gain: assert property (p_gain) else $error("gain code wrong");

   property p_right;
      @(posedge pclk) disable iff (!presetn)
      (run_r && sample_valid && cfg_r.pbe && !cfg_r.pick) |=>
         (ch_a_sample == $past(right_sample) && ch_b_sample == $past(right_sample));
   endproperty
   a_right: assert property (p_right) else $error("right channel not played");

   property p_left;
      @(posedge pclk) disable iff (!presetn)
      (run_r && sample_valid && cfg_r.pbe && cfg_r.pick) |=> (ch_b_sample == $past(left_sample));
   endproperty
   a_left: assert property (p_left) else $error("left channel not played");

   property p_fault_rd;
      @(posedge pclk) disable iff (!presetn)
      (setup && paddr == AOCR_ADDR_FAULT) |=> (prdata[31:6] == 26'h0 && prdata[3:0] == $past(flt_r));
   endproperty
   a_fault_rd: assert property (p_fault_rd) else $error("fault register layout wrong");

   property p_pct;
      @(posedge pclk) disable iff (!presetn)
      ##1 (ocl_percent == 7'(7'd100 - 7'd25 * {5'h0, $past(thr_r)}));
   endproperty
   a_pct: assert property (p_pct) else $error("threshold percent wrong");

   property p_clk;
      @(posedge pclk) disable iff (!presetn)
      $fell(pin_sync_r[3]) |=> !flt_r.clk;
   endproperty
   a_clk: assert property (p_clk) else $error("clock fault flag stuck");

   property p_latch;
      @(posedge pclk) disable iff (!presetn)
      (flt_r.ovc && !sd_toggle) |=> (flt_r.ovc && !amp_run);
   endproperty
   a_latch: assert property (p_latch) else $error("overcurrent not latched");
endmodule // aocr_top
`default_nettype wire

// >>> include/aocr_pkg.sv
`default_nettype none
package aocr_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] AOCR_IDX_OUTCFG   = 8'h06;
   localparam logic [7:0] AOCR_IDX_RSVD7    = 8'h07;
   localparam logic [7:0] AOCR_IDX_FAULT    = 8'h08;
   localparam logic [7:0] AOCR_IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] AOCR_IDX_IRQ_MASK = 8'h11;
   localparam logic [7:0] AOCR_ADDR_OUTCFG   = AOCR_IDX_OUTCFG << 2;
   localparam logic [7:0] AOCR_ADDR_RSVD7    = AOCR_IDX_RSVD7 << 2;
   localparam logic [7:0] AOCR_ADDR_FAULT    = AOCR_IDX_FAULT << 2;
   localparam logic [7:0] AOCR_ADDR_IRQ_STAT = AOCR_IDX_IRQ_STAT << 2;
   localparam logic [7:0] AOCR_ADDR_IRQ_MASK = AOCR_IDX_IRQ_MASK << 2;
   // Values after reset.
   localparam logic [7:0] AOCR_OUTCFG_RST = 8'h51;
   localparam logic [1:0] AOCR_THR_RST    = 2'h0;
   localparam logic [3:0] AOCR_IRQ_RST    = 4'h0;
   // Reserved gain code that a write may not install.
   localparam logic [1:0] AOCR_GAIN_RSVD  = 2'h3;
   // Fault register field positions.
   localparam int AOCR_FLT_THR_LO = 4;
   localparam int AOCR_FLT_CLK    = 3;
   localparam int AOCR_FLT_OVC    = 2;
   localparam int AOCR_FLT_DC     = 1;
   localparam int AOCR_FLT_OT     = 0;
   // Number of synchronised pins.
   localparam int AOCR_NPIN = 6;

   // Output configuration register layout, bit 7 first.
   typedef struct packed {
      logic       pbe;   // Paralleled bridge enable.
      logic [2:0] rate;  // Switching rate select.
      logic [1:0] gain;  // Analog gain code.
      logic       pick;  // Mono channel pick.
      logic       rsvd;  // Reserved, read and write.
   } aocr_cfg_t;

   // Fault flags as seen by software.
   typedef struct packed {
      logic clk;  // Clock fault, follows the input.
      logic ovc;  // Overcurrent, latched.
      logic dc;   // Output offset, latched.
      logic ot;   // Overtemperature, latched.
   } aocr_flt_t;

   // Multiple of the frame sync clock for each rate code.
   function automatic logic [4:0] aocr_rate_mult(input logic [2:0] code);
      unique case (code)
         3'h0: aocr_rate_mult = 5'h06;
         3'h1: aocr_rate_mult = 5'h08;
         3'h2: aocr_rate_mult = 5'h0a;
         3'h3: aocr_rate_mult = 5'h0c;
         3'h4: aocr_rate_mult = 5'h0e;
         3'h5: aocr_rate_mult = 5'h10;
         3'h6: aocr_rate_mult = 5'h14;
         3'h7: aocr_rate_mult = 5'h18;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> dv/amp_output_config_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module amp_output_config_regs_bench
   import aocr_pkg::*;
;
   // APB master side and pin drivers.
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        pready, pslverr, er;
   logic        double_speed, clock_error_pin, overcurrent_pin, dc_offset_pin, overtemp_pin;
   logic        speaker_shutdown_n, sample_valid, paralleled_bridge_mode, amp_run, irq;
   logic [23:0] left_sample, right_sample, ch_a_sample, ch_b_sample;
   logic [4:0]  switch_mult;
   logic [1:0]  amp_gain_code;
   logic [6:0]  ocl_percent;
   int          num_errors, compares, cycles;
   // Expected switching multiples and threshold percentages per code.
   // Code 0 sits in the lowest slice of each table.
   localparam logic [39:0] MULT = {5'h18, 5'h14, 5'h10, 5'h0e, 5'h0c, 5'h0a, 5'h08, 5'h06};
   localparam logic [27:0] PCT  = {7'h19, 7'h32, 7'h4b, 7'h64};

   aocr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .double_speed(double_speed), .clock_error_pin(clock_error_pin), .overcurrent_pin(overcurrent_pin),
      .dc_offset_pin(dc_offset_pin), .overtemp_pin(overtemp_pin), .speaker_shutdown_n(speaker_shutdown_n),
      .sample_valid(sample_valid), .left_sample(left_sample), .right_sample(right_sample),
      .paralleled_bridge_mode(paralleled_bridge_mode), .switch_mult(switch_mult),
      .amp_gain_code(amp_gain_code), .ocl_percent(ocl_percent), .ch_a_sample(ch_a_sample),
      .ch_b_sample(ch_b_sample), .amp_run(amp_run), .irq(irq));

   // A 50 ns clock.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Compares one value and counts it; a mismatch is reported at once.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready is sampled high; if it never rises, only the bench timeout ends this wait.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Writes the output config; bit 0 is always written back as 1.
   task automatic wcfg(input logic m, input logic [2:0] r, input logic [1:0] g, input logic p);
      apb(1'b1, AOCR_ADDR_OUTCFG, {24'h0, m, r, g, p, 1'b1});
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic test_done;
      $display("Checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Register and output values straight after reset.
   task automatic t_reset;
      apb(1'b0, AOCR_ADDR_OUTCFG, 32'h0);
      chk("outcfg", rd, 32'h51);
      apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
      chk("fault", rd, 32'h0);
      chk("mult", switch_mult, 5'h10);
      chk("pct", ocl_percent, 7'h64);
      $display("reset test done");
   endtask

   // Every rate code in single and double speed.
   task automatic t_rate;
      for (int ds = 0; ds < 2; ds++) begin
         @(posedge pclk);
         double_speed <= ds[0];
         for (int c = 0; c < 8; c++) begin
            wcfg(1'b0, c[2:0], 2'h0, 1'b0);
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk("mult", switch_mult, MULT[c*5 +: 5] >> ds);
         end
      end
      @(posedge pclk);
      double_speed <= 1'b0;
      $display("rate test done");
   endtask

   // Gain codes, the refused gain code and every threshold code.
   task automatic t_gain;
      for (int g = 0; g < 3; g++) begin
         wcfg(1'b0, 3'h5, g[1:0], 1'b0);
         chk("gain", amp_gain_code, g[1:0]);
      end
      wcfg(1'b0, 3'h5, AOCR_GAIN_RSVD, 1'b1);
      chk("gain", amp_gain_code, 2'h2);
      apb(1'b0, AOCR_ADDR_OUTCFG, 32'h0);
      chk("outcfg", rd, 32'h5b);
      for (int t = 3; t >= 0; t--) begin
         apb(1'b1, AOCR_ADDR_FAULT, 32'(t << 4));
         // The percentage register follows the threshold one edge later.
         @(posedge pclk);
         @(negedge pclk);
         chk("pct", ocl_percent, PCT[t*7 +: 7]);
         apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
         chk("fault", rd, 32'(t << 4));
      end
      $display("gain test done");
   endtask

   // Bridged and paralleled modes with both channel picks.
   task automatic t_mode;
      for (int i = 0; i < 4; i++) begin
         wcfg(i[1], 3'h5, 2'h0, i[0]);
         chk("mode", paralleled_bridge_mode, i[1]);
         @(posedge pclk);
         left_sample  <= 24'h123456;
         right_sample <= 24'h654321;
         sample_valid <= 1'b1;
         @(posedge pclk);
         sample_valid <= 1'b0;
         @(negedge pclk);
         chk("cha", ch_a_sample, !i[1] ? 24'h123456 : i[0] ? 24'h123456 : 24'h654321);
         chk("chb", ch_b_sample, !i[1] ? 24'h654321 : i[0] ? 24'h123456 : 24'h654321);
      end
      $display("mode test done");
   endtask

   // Reserved slot seven and an unmapped address are refused.
   task automatic t_rsvd;
      apb(1'b1, AOCR_ADDR_RSVD7, 32'hff);
      chk("err", er, 1'b1);
      apb(1'b0, AOCR_ADDR_RSVD7, 32'h0);
      chk("rsvd", {er, rd}, {1'b1, 32'h0});
      apb(1'b0, 8'h7c, 32'h0);
      chk("err", er, 1'b1);
      // A write with the low byte strobe off must leave the register alone.
      pstrb <= 4'h0;
      apb(1'b1, AOCR_ADDR_OUTCFG, 32'h01);
      pstrb <= 4'hf;
      apb(1'b0, AOCR_ADDR_OUTCFG, 32'h0);
      chk("outcfg", {er, rd}, {1'b0, 32'hd3});
      $display("reserved test done");
   endtask

   // Fault flags, the shutdown toggle and the interrupt.
   task automatic t_fault;
      clock_error_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
      chk("fault", rd, 32'h08);
      clock_error_pin <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
      chk("fault", rd, 32'h0);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         {overcurrent_pin, dc_offset_pin, overtemp_pin} <= 3'(1 << i);
         repeat (5) @(posedge pclk);
         {overcurrent_pin, dc_offset_pin, overtemp_pin} <= 3'h0;
         repeat (5) @(posedge pclk);
         apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
         chk("fault", rd, 32'(1 << i));
         @(negedge pclk);
         chk("run", {amp_run, ch_a_sample}, 25'h0);
         @(posedge pclk);
         speaker_shutdown_n <= 1'b0;
         repeat (6) @(posedge pclk);
         speaker_shutdown_n <= 1'b1;
         repeat (6) @(posedge pclk);
         apb(1'b0, AOCR_ADDR_FAULT, 32'h0);
         chk("fault", rd, 32'h0);
         @(negedge pclk);
         chk("run", amp_run, 1'b1);
      end
      chk("irq", irq, 1'b0);
      apb(1'b1, AOCR_ADDR_IRQ_MASK, 32'h4);
      @(negedge pclk);
      chk("irq", irq, 1'b1);
      apb(1'b0, AOCR_ADDR_IRQ_STAT, 32'h0);
      chk("stat", rd, 32'h0f);
      @(negedge pclk);
      chk("irq", irq, 1'b0);
      apb(1'b0, AOCR_ADDR_IRQ_STAT, 32'h0);
      chk("stat", rd, 32'h0);
      $display("fault test done");
   endtask

   // Cuts a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end

   // Main sequence.
   initial begin
      num_errors = 0; compares = 0; cycles = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      pstrb = 4'hf; double_speed = 1'b0; clock_error_pin = 1'b0; overcurrent_pin = 1'b0;
      dc_offset_pin = 1'b0; overtemp_pin = 1'b0; speaker_shutdown_n = 1'b1; sample_valid = 1'b0;
      left_sample = 24'h0; right_sample = 24'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rate();
      t_gain();
      t_mode();
      t_rsvd();
      t_fault();
      test_done();
   end
endmodule // amp_output_config_regs_bench
`default_nettype wire
